/* File: hci_commutation.sv */
//==========================================================
// Purpose: rotor electrical angle init, tracking, phase refs
// Assumes: hall and encoder pins asynchronous, 125 MHz clock
// Notes: phase-finding algorithm supplies its own angle
// How it works
// RL1: two init schemes, rotor-moving phase find or hall-only without motion
// RL2: after init, encoder counts advance the absolute angle
// RL3: three hall bits; six of eight codes valid, once per turn
// RL4: each valid code is a 60 degree sector; one bit per step
// RL5: at power-up hall sector centre loads as working angle
// RL6: on motion, first hall edge snaps angle to boundary value
// RL7: hall init drives no phase-finding current
// RL8: refs are amp*sin(angle), sin(angle-120), sin(angle-240)
// RL9: mechanical angle equals electrical times 2/N poles
// RL10: invert is 0 or -1, reverses rotation; change while disabled
// RL11: save request while drive disabled writes config with invert into nonvolatile store
// RL12: U,UV,V,VW,W,WU counts up unless encoder reverse set
// RL13: fault on code 000, 111 or multi-bit hall change
`timescale 1ns/100ps
module hci_commutation
  import hci_pkg::*;
#(
  parameter int POLES = HCI_POLES_DEF,
  parameter int ENC_CPR = HCI_CPR_DEF
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] hall_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic init_mode_move,
  input wire logic drive_enable,
  input wire logic motion_cmd,
  input wire logic encoder_reverse,
  input wire logic direction_invert_param,
  input wire logic nvm_invert_value,
  input wire logic nvm_valid,
  input wire logic save_req,
  input wire logic find_done,
  input wire logic [HCI_ANG_W-1:0] find_angle,
  input wire logic signed [HCI_AMP_W-1:0] current_amp,
  output logic signed [HCI_AMP_W-1:0] phase_r_current_ref,
  output logic signed [HCI_AMP_W-1:0] phase_s_current_ref,
  output logic signed [HCI_AMP_W-1:0] phase_t_current_ref,
  output logic phase_find_active,
  output logic commutation_fault,
  output logic angle_exact,
  output logic [HCI_ANG_W-1:0] elec_angle,
  output logic [HCI_ANG_W-1:0] mech_angle,
  output logic invert_active,
  output logic nvm_write,
  output logic nvm_write_data
);
  localparam logic [HCI_ANG_W-1:0] ENC_STEP =
    HCI_ANG_W'((65536 * POLES / 2 + 2 * ENC_CPR) / (4 * ENC_CPR));

  hci_sine_if sif ();

  //==========================================================
  // pin synchronisers
  logic [4:0] sync1_reg, sync2_reg, prev_reg;
  // no reset: chain holds the live pins when reset ends
  always_ff @(posedge clk) begin
    sync1_reg <= {enc_b, enc_a, hall_in};
    sync2_reg <= sync1_reg;
    prev_reg <= sync2_reg;
  end
  logic [2:0] hall_s, hall_p;
  assign hall_s = sync2_reg[2:0];
  assign hall_p = prev_reg[2:0];

  //==========================================================
  // hall decode: U=001 V=010 W=100
  function automatic logic [2:0] sector_of(input logic [2:0] h);
    case (h)
      3'h1: sector_of = 3'd0; // RL4
      3'h3: sector_of = 3'd1;
      3'h2: sector_of = 3'd2;
      3'h6: sector_of = 3'd3;
      3'h4: sector_of = 3'd4;
      3'h5: sector_of = 3'd5;
      default: sector_of = 3'd0;
    endcase
  endfunction

  function automatic logic [HCI_ANG_W-1:0] sec_base(input logic [2:0] s);
    sec_base = HCI_ANG_W'(s * HCI_SEC_STEP);
  endfunction

  logic hall_valid, hall_chg, multi_chg, fwd_edge;
  logic [2:0] sec_now, sec_prev, diff;
  always_comb begin
    hall_valid = hall_s != HCI_HALL_ALL_LOW
      && hall_s != HCI_HALL_ALL_HIGH; // RL3
    diff = hall_s ^ hall_p;
    hall_chg = diff != 3'h0;
    multi_chg = hall_chg && !(diff == 3'h1 || diff == 3'h2
      || diff == 3'h4); // RL4
    sec_now = sector_of(hall_s);
    sec_prev = sector_of(hall_p);
    fwd_edge = sec_now == ((sec_prev == 3'd5) ? 3'd0 : 3'(sec_prev + 3'd1));
  end

  //==========================================================
  // encoder quadrature
  logic enc_up, enc_dn;
  always_comb begin
    logic ch;
    ch = (sync2_reg[3] ^ prev_reg[3]) | (sync2_reg[4] ^ prev_reg[4]);
    enc_up = ch && ((sync2_reg[3] ^ prev_reg[4]) != encoder_reverse);
    enc_dn = ch && !enc_up; // RL12
  end

  //==========================================================
  // angle state machine
  hci_state_t st_reg, st_next;
  logic [HCI_ANG_W-1:0] ang_reg, ang_next;
  logic exact_reg, exact_next, fault_reg, fault_next;
  logic inv_reg, inv_next, started_reg, started_next;
  logic wr_reg, wr_next, wd_reg, wd_next;

  always_comb begin
    st_next = st_reg;
    ang_next = ang_reg;
    exact_next = exact_reg;
    fault_next = fault_reg || (st_reg != HCI_ST_IDLE
      && (!hall_valid || multi_chg)); // RL13
    started_next = 1'b1;
    inv_next = drive_enable ? inv_reg : direction_invert_param; // RL10
    if (!started_reg && nvm_valid) begin
      inv_next = nvm_invert_value; // RL11
    end
    wr_next = save_req && !drive_enable; // RL11
    wd_next = save_req ? inv_reg : wd_reg; // RL11
    if (enc_up) begin
      ang_next = HCI_ANG_W'(ang_reg + ENC_STEP); // RL2
    end else if (enc_dn) begin
      ang_next = HCI_ANG_W'(ang_reg - ENC_STEP); // RL2
    end
    case (st_reg)
      HCI_ST_IDLE: begin
        if (started_reg) begin
          if (init_mode_move) begin
            st_next = HCI_ST_PHASE_FIND; // RL1
          end else begin
            ang_next = HCI_ANG_W'(sec_base(sec_now) + HCI_ANG_30); // RL5
            st_next = HCI_ST_WAIT_EDGE; // RL1
          end
        end
      end
      HCI_ST_PHASE_FIND: begin
        if (find_done) begin
          ang_next = find_angle;
          exact_next = 1'b1;
          st_next = HCI_ST_LOCKED;
        end
      end
      HCI_ST_WAIT_EDGE: begin
        if (motion_cmd && hall_chg && hall_valid && !multi_chg) begin
          ang_next = fwd_edge ? sec_base(sec_now)
            : sec_base(sec_prev); // RL6
          exact_next = 1'b1;
          st_next = HCI_ST_LOCKED;
        end
      end
      HCI_ST_LOCKED: st_next = HCI_ST_LOCKED;
      default: st_next = HCI_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= HCI_ST_IDLE;
      ang_reg <= '0;
      exact_reg <= 1'b0;
      fault_reg <= 1'b0;
      inv_reg <= 1'b0;
      started_reg <= 1'b0;
      wr_reg <= 1'b0;
      wd_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ang_reg <= ang_next;
      exact_reg <= exact_next;
      fault_reg <= fault_next;
      inv_reg <= inv_next;
      started_reg <= started_next;
      wr_reg <= wr_next;
      wd_reg <= wd_next;
    end
  end

  //==========================================================
  // outputs
  logic [HCI_ANG_W-1:0] mech_next;
  logic pf_next;
  logic [HCI_ANG_W-1:0] mech_reg;
  logic pf_reg;
  always_comb begin
    mech_next = HCI_ANG_W'((32'(ang_reg) * 2) / POLES); // RL9
    pf_next = st_next == HCI_ST_PHASE_FIND && drive_enable; // RL7
  end
  always_ff @(posedge clk) begin
    mech_reg <= rst_n ? mech_next : '0;
    pf_reg <= rst_n ? pf_next : 1'b0;
  end

  assign sif.angle = ang_reg;
  assign sif.amp = (drive_enable && st_reg != HCI_ST_IDLE
    && st_reg != HCI_ST_PHASE_FIND)
    ? (inv_reg ? HCI_AMP_W'(-current_amp) : current_amp) : '0; // RL10

  hci_sine3 u_sine (
    .clk(clk),
    .rst_n(rst_n),
    .sif(sif.sink)
  );

  assign phase_r_current_ref = sif.ref_r;
  assign phase_s_current_ref = sif.ref_s;
  assign phase_t_current_ref = sif.ref_t;
  assign phase_find_active = pf_reg;
  assign commutation_fault = fault_reg;
  assign angle_exact = exact_reg;
  assign elec_angle = ang_reg;
  assign mech_angle = mech_reg;
  assign invert_active = inv_reg;
  assign nvm_write = wr_reg;
  assign nvm_write_data = wd_reg;
endmodule // hci_commutation

/* File: hci_pkg.sv */
//==========================================================
// Purpose: shared constants and types for hall commutation init
// Assumes: angle is an unsigned fraction of one electrical turn
// Notes: sixty degrees of a turn is 1/6 of 2^ANG_W
package hci_pkg;
  localparam int HCI_ANG_W = 16;
  localparam int HCI_AMP_W = 12;
  localparam int HCI_LUT_W = 6;
  localparam int HCI_POLES_DEF = 4;
  localparam int HCI_CPR_DEF = 4000;
  localparam logic [15:0] HCI_SEC_STEP = 16'h2AAA;
  localparam logic [15:0] HCI_ANG_120 = 16'h5555;
  localparam logic [15:0] HCI_ANG_240 = 16'hAAAA;
  localparam logic [15:0] HCI_ANG_30 = 16'h1555;
  localparam logic [2:0] HCI_HALL_ALL_LOW = 3'h0;
  localparam logic [2:0] HCI_HALL_ALL_HIGH = 3'h7;
  localparam logic [1:0] HCI_INIT_HALL = 2'h0;
  localparam logic [1:0] HCI_INIT_MOVE = 2'h1;

  typedef enum logic [3:0] {
    HCI_ST_IDLE = 4'b0001,
    HCI_ST_PHASE_FIND = 4'b0010,
    HCI_ST_WAIT_EDGE = 4'b0100,
    HCI_ST_LOCKED = 4'b1000
  } hci_state_t;
endpackage

/* File: hci_sine_if.sv */
//==========================================================
// Purpose: carries the angle and amplitude to the sine unit
// Assumes: one clock domain
// Notes: results are registered inside the sine unit
`timescale 1ns/100ps
interface hci_sine_if;
  import hci_pkg::*;
  logic [HCI_ANG_W-1:0] angle;
  logic signed [HCI_AMP_W-1:0] amp;
  logic signed [HCI_AMP_W-1:0] ref_r;
  logic signed [HCI_AMP_W-1:0] ref_s;
  logic signed [HCI_AMP_W-1:0] ref_t;
  modport src (output angle, output amp, input ref_r, input ref_s,
    input ref_t);
  modport sink (input angle, input amp, output ref_r, output ref_s,
    output ref_t);
endinterface

/* File: hci_sine3.sv */
//==========================================================
// Purpose: three-phase sine references from one angle
// Assumes: 64-entry sine table, amplitude signed
// Notes: one cycle of latency
`timescale 1ns/100ps
module hci_sine3
  import hci_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  hci_sine_if.sink sif
);
  logic [HCI_ANG_W-1:0] ph [3];
  logic signed [HCI_AMP_W-1:0] ref_reg [3];
  logic signed [HCI_AMP_W-1:0] ref_next [3];

  //==========================================================
  // sine table
  function automatic logic signed [15:0] sin_lut(
    input logic [HCI_LUT_W-1:0] idx);
    logic signed [15:0] q [16];
    logic [3:0] k;
    q = '{16'sh0000, 16'sh0C8C, 16'sh18F9, 16'sh2528, 16'sh30FC,
      16'sh3C57, 16'sh471D, 16'sh5134, 16'sh5A82, 16'sh62F2,
      16'sh6A6E, 16'sh70E3, 16'sh7642, 16'sh7A7D, 16'sh7D8A,
      16'sh7F62};
    k = idx[4] ? 4'(~idx[3:0] + 4'h1) : idx[3:0];
    sin_lut = (idx[4] && idx[3:0] == 4'h0) ? 16'sh7FFF : q[k];
    if (idx[5]) begin
      sin_lut = -sin_lut;
    end
  endfunction

  //==========================================================
  // phase offsets and scaling
  assign ph[0] = sif.angle; // RL8
  assign ph[1] = HCI_ANG_W'(sif.angle - HCI_ANG_120); // RL8
  assign ph[2] = HCI_ANG_W'(sif.angle - HCI_ANG_240); // RL8

  always_comb begin
    logic signed [HCI_AMP_W+16:0] prod;
    prod = '0;
    for (int i = 0; i < 3; i++) begin
      prod = sif.amp * sin_lut(ph[i][HCI_ANG_W-1 -: HCI_LUT_W]);
      ref_next[i] = HCI_AMP_W'(prod >>> 15); // RL8
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      ref_reg[i] <= rst_n ? ref_next[i] : '0;
    end
  end

  assign sif.ref_r = ref_reg[0];
  assign sif.ref_s = ref_reg[1];
  assign sif.ref_t = ref_reg[2];
endmodule // hci_sine3

/* File: hci_chk.sv */
//==========================================================
// Purpose: port checker for hci_commutation
// Assumes: bound to every instance
// Notes: one clock domain
`timescale 1ns/100ps
module hci_chk
  import hci_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] hall_in,
  input wire logic init_mode_move,
  input wire logic drive_enable,
  input wire logic motion_cmd,
  input wire logic save_req,
  input wire logic signed [HCI_AMP_W-1:0] phase_r_current_ref,
  input wire logic phase_find_active,
  input wire logic commutation_fault,
  input wire logic angle_exact,
  input wire logic invert_active,
  input wire logic nvm_write,
  input wire logic nvm_write_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_flt_hold; commutation_fault |=> commutation_fault; endproperty
  a_flt_hold: assert property (p_flt_hold) else $error("fault fell");
  property p_flt_code;
    (hall_in == HCI_HALL_ALL_LOW || hall_in == HCI_HALL_ALL_HIGH) [*8]
      |-> commutation_fault;
  endproperty
  a_flt_code: assert property (p_flt_code) else $error("no fault");
  property p_exa_hold; angle_exact |=> angle_exact; endproperty
  a_exa_hold: assert property (p_exa_hold) else $error("exact fell");
  property p_exa_mot;
    $rose(angle_exact) && !init_mode_move |-> $past(motion_cmd);
  endproperty
  a_exa_mot: assert property (p_exa_mot) else $error("exact no motion");
  property p_no_find; !init_mode_move |-> !phase_find_active; endproperty
  a_no_find: assert property (p_no_find) else $error("find in hall");
  property p_find_ref;
    phase_find_active && $past(phase_find_active) |-> phase_r_current_ref == 0;
  endproperty
  a_find_ref: assert property (p_find_ref) else $error("ref in find");
  property p_inv_hold;
    drive_enable && $past(drive_enable) |-> $stable(invert_active);
  endproperty
  a_inv_hold: assert property (p_inv_hold) else $error("inv moved");
  property p_nvm_wr;
    nvm_write |-> $past(save_req) && !$past(drive_enable) &&
      nvm_write_data == $past(invert_active);
  endproperty
  a_nvm_wr: assert property (p_nvm_wr) else $error("bad nvm write");
endmodule // hci_chk
bind hci_commutation hci_chk u_chk (.clk(clk), .rst_n(rst_n),
  .hall_in(hall_in), .init_mode_move(init_mode_move),
  .drive_enable(drive_enable), .motion_cmd(motion_cmd),
  .save_req(save_req), .phase_r_current_ref(phase_r_current_ref),
  .phase_find_active(phase_find_active),
  .commutation_fault(commutation_fault), .angle_exact(angle_exact),
  .invert_active(invert_active), .nvm_write(nvm_write),
  .nvm_write_data(nvm_write_data));

/* File: hci_motor_model.sv */
//==========================================================
// Purpose: hall sensors and quadrature encoder of the motor
// Assumes: caller spaces steps by several clocks
// Notes: a leads b for forward motion
`timescale 1ns/100ps
module hci_motor_model (
  output logic [2:0] hall_in,
  output logic enc_a,
  output logic enc_b
);
  logic [2:0] codes [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int sec = 0;
  int ph = 0;
  initial begin
    hall_in = 3'h1;
    enc_a = 1'b0;
    enc_b = 1'b0;
  end
  task automatic hall_step(input int dir);
    sec = (sec + dir + 6) % 6;
    hall_in = codes[sec];
  endtask
  task automatic set_code(input logic [2:0] c);
    sec = 0;
    hall_in = c;
  endtask
  task automatic quad(input int dir);
    ph = (ph + dir + 4) % 4;
    enc_a = (ph == 1 || ph == 2);
    enc_b = (ph >= 2);
  endtask
endmodule // hci_motor_model

/* File: testbench.sv */
//==========================================================
// Purpose: self-checking bench for hci_commutation
// Assumes: POLES 4, ENC_CPR 64 gives 512 per edge
// Notes: inputs change at falling edge
`timescale 1ns/100ps
module testbench
  import hci_pkg::*;
;
  logic clk = 0, rst_n = 0, mm = 0, en = 0, mot = 0, erev = 0, dinv = 0;
  logic nv = 0, nvv = 0, sreq = 0, fdone = 0;
  logic [15:0] fang = 16'h0000;
  logic signed [11:0] amp = 12'sh400;
  logic [2:0] hall;
  logic ea, eb, pfa, flt, exa, inv, nw, nwd;
  logic signed [11:0] rr, rs, rt;
  logic [15:0] ang, mech;
  int mismatches = 0, n_compared = 0;
  hci_motor_model m (.hall_in(hall), .enc_a(ea), .enc_b(eb));
  hci_commutation #(.POLES(4), .ENC_CPR(64)) u_dut (.clk(clk),
    .rst_n(rst_n), .hall_in(hall), .enc_a(ea), .enc_b(eb),
    .init_mode_move(mm), .drive_enable(en), .motion_cmd(mot),
    .encoder_reverse(erev), .direction_invert_param(dinv),
    .nvm_invert_value(nvv), .nvm_valid(nv), .save_req(sreq),
    .find_done(fdone), .find_angle(fang), .current_amp(amp),
    .phase_r_current_ref(rr), .phase_s_current_ref(rs),
    .phase_t_current_ref(rt), .phase_find_active(pfa),
    .commutation_fault(flt), .angle_exact(exa), .elec_angle(ang),
    .mech_angle(mech), .invert_active(inv), .nvm_write(nw),
    .nvm_write_data(nwd));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp_v(input logic [15:0] g, e, input string s);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t %s %h", $time, s, g);
    end
  endtask
  task automatic cmp_b(input logic g, e, input string s);
    cmp_v({15'h0000, g}, {15'h0000, e}, s);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset(input logic mode, v);
    @(negedge clk);
    rst_n = 0;
    en = 0;
    mot = 0;
    mm = mode;
    nv = v;
    nvv = v;
    cyc(5);
    rst_n = 1;
    cyc(1);
    cmp_b(inv, v | dinv, "restore");
    cyc(5);
  endtask
  task automatic t_hall();
    m.set_code(3'h1);
    do_reset(0, 0);
    cmp_v(ang, HCI_ANG_30, "init");
    cmp_v(mech, 16'(HCI_ANG_30 / 2), "mech");
    cmp_b(pfa, 0, "find");
    m.hall_step(1);
    cyc(8);
    cmp_b(exa, 0, "early");
    m.hall_step(-1);
    cyc(8);
    en = 1;
    mot = 1;
    m.hall_step(1);
    for (int i = 0; i < 20 && exa !== 1'b1; i++) cyc(1);
    cmp_v(ang, HCI_SEC_STEP, "edge");
    cyc(3);
    cmp_b(rr > 12'sd700 && rr <= amp, 1, "ref r");
    cmp_b(rs < -12'sd700 && rt < 12'sd160 && rt > -12'sd160, 1, "s t");
  endtask
  task automatic t_enc();
    for (int i = 0; i < 4; i++) begin m.quad(1); cyc(6); end
    cmp_v(ang, HCI_SEC_STEP + 16'h0800, "enc up");
    erev = 1;
    for (int i = 0; i < 4; i++) begin m.quad(1); cyc(6); end
    cmp_v(ang, HCI_SEC_STEP, "enc rev");
    erev = 0;
  endtask
  task automatic t_inv();
    amp = 12'sh600;
    en = 0;
    dinv = 1;
    cyc(3);
    cmp_b(inv, 1, "inv");
    en = 1;
    cyc(4);
    cmp_b(rr < -12'sd1100 && rr >= -amp, 1, "inv ref");
    dinv = 0;
    sreq = 1;
    cyc(1);
    sreq = 0;
    cmp_b(nw, 0, "refused");
    cyc(3);
    cmp_b(inv, 1, "held");
    en = 0;
    dinv = 1;
    sreq = 1;
    cyc(1);
    sreq = 0;
    cmp_b(nw & nwd, 1, "save");
  endtask
  task automatic t_move();
    dinv = 0;
    do_reset(1, 1);
    en = 1;
    cyc(1);
    cmp_b(pfa, 1, "find");
    fang = 16'h4000;
    fdone = 1;
    cyc(1);
    fdone = 0;
    cyc(3);
    cmp_v(ang, 16'h4000, "find ang");
  endtask
  task automatic t_back();
    m.set_code(3'h1);
    do_reset(0, 0);
    en = 1;
    mot = 1;
    m.hall_step(-1);
    cyc(6);
    cmp_b(exa, 1, "back exact");
    cmp_v(ang, 16'h0000, "back edge");
    cmp_b(flt, 0, "back fault");
  endtask
  task automatic t_fault(input logic [2:0] c);
    m.set_code(3'h1);
    do_reset(0, 0);
    cmp_b(flt, 0, "clean");
    m.set_code(c);
    cyc(8);
    cmp_b(flt, 1, "fault");
  endtask
  initial begin
    t_hall();
    t_enc();
    t_inv();
    t_move();
    t_fault(3'h2);
    t_fault(HCI_HALL_ALL_LOW);
    t_fault(HCI_HALL_ALL_HIGH);
    t_back();
    finish_test();
  end
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end
endmodule // testbench
